// file: expander_pkg.sv
// package for the ten-bit serial output expander
// assumes a single mclk domain; pins are asynchronous to it
package expander_pkg;

    // ==========================================================
    // geometry
    localparam int unsigned STAGES     = 10;
    localparam int unsigned FIFO_WIDTH = 1;
    localparam int unsigned FIFO_DEPTH = 8;

    // ==========================================================
    // reset values
    localparam logic [9:0] SHIFT_RESET = 10'h000;

    // ==========================================================
    // timing: longest strobe-high time, counted in mclk cycles
    localparam longint unsigned CLK_HZ         = 20000000;
    localparam longint unsigned STROBE_MAX_MS  = 10;
    localparam longint unsigned STROBE_MAX_CYC =
        (STROBE_MAX_MS * CLK_HZ) / 1000;

    // ==========================================================
    // types
    typedef enum logic [1:0]
    {
        STROBE_IDLE = 2'b00,
        STROBE_HIGH = 2'b01,
        STROBE_LATE = 2'b11
    } strobe_state_t;

    typedef struct packed
    {
        logic [9:0] parallel;
        logic       serial;
    } expander_out_t;

endpackage

// file: bit_fifo.sv
// small valid/ready fifo for captured serial bits
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
module bit_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 8
)(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshake terms
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    // storage, no reset needed on data
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

// file: serial_output_expander.sv
// ten-stage serial-in, parallel-out, serial-out expander
// holds pin synchronisers, the shift stages and the output gating
// assumes pins arrive asynchronous to mclk and are synchronised here
// assumes the driving port keeps strobe pulses well inside the limit
// one mclk domain; nothing in here is reached by software
`timescale 1ns/10ps
module serial_output_expander (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // pins from the driving port
    input  wire logic       shift_strobe,
    input  wire logic       serial_in,
    input  wire logic       output_gate,
    // pins toward the load
    output logic [9:0]      parallel_out,
    output logic            serial_out,
    // diagnostic: strobe held beyond its longest width
    output logic            strobe_overlong
);
    // ==========================================================
    // pin synchronisers: first stage read only by the second
    // the gate, data and strobe pins share one synchroniser bank
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    // strobe runs one flop behind the data after synchronising, so a
    // data change made together with the strobe edge has settled first
    logic       strobe_d_r;
    logic       strobe_d2_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {output_gate, serial_in, shift_strobe};
            sync2_r <= sync1_r;
        end
    end

    // extra strobe delay so a data edge arriving together is settled;
    // costs one cycle of latency, which is nothing next to the pin
    // timing of a port that is itself driven by software
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            strobe_d_r  <= 1'b0;
            strobe_d2_r <= 1'b0;
        end
        else
        begin
            strobe_d_r  <= sync2_r[0];
            strobe_d2_r <= strobe_d_r;
        end
    end

    // rising edge seen one cycle after the data has reached sync2_r;
    // both delay flops reset low like the idle pin, so no false edge
    logic rise;
    assign rise = strobe_d_r && !strobe_d2_r;

    // ==========================================================
    // captured bits pass through the fifo before shifting
    // the fifo decouples edge capture from the shift, so a stall on
    // the shift side later on would not cost a strobe; the drain is
    // free here, so it never holds more than one bit
    logic fifo_out_data;
    logic fifo_out_valid;
    logic fifo_in_ready;

    bit_fifo #(
        .WIDTH (expander_pkg::FIFO_WIDTH),
        .DEPTH (expander_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_data   (sync2_r[1]),
        .in_valid  (rise),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1)
    );

    // ==========================================================
    // the register itself; fifo never backs up since drain is free
    // shifting toward bit nine keeps parallel bit zero as the newest
    // stage, which is what a chained unit's serial input expects;
    // stages hold between strobes however long the gap is
    logic [9:0] stage_r;
    logic       drop_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            stage_r <= expander_pkg::SHIFT_RESET;
        else if (fifo_out_valid)
            stage_r <= {stage_r[8:0], fifo_out_data};
    end

    // a strobe lost to a full fifo is remembered, not silently ignored
    // with a free drain the fifo cannot fill; kept as a guard only
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            drop_r <= 1'b0;
        else if (rise && !fifo_in_ready)
            drop_r <= 1'b1;
    end

    // ==========================================================
    // registered outputs; gate clears parallel view only
    // the gate acts on the view, never on stage_r, so closing and
    // reopening the gate shows the same contents again
    expander_pkg::expander_out_t out_nxt;
    logic [9:0]                  gated_view;

    // one and-gate per stage, all sharing the synchronised gate
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1)
        begin : g_view
            assign gated_view[gi] = stage_r[gi] && sync2_r[2];
        end
    endgenerate

    // serial view taps stage_r directly: gating it would cut a chain
    always_comb
    begin
        out_nxt.parallel = gated_view;
        out_nxt.serial   = stage_r[9];
    end

    // outputs straight from flops, so the pins never glitch when the
    // gate and the stages change in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            parallel_out <= 10'h000;
            serial_out   <= 1'b0;
        end
        else
        begin
            parallel_out <= out_nxt.parallel;
            serial_out   <= out_nxt.serial;
        end
    end

    // ==========================================================
    // strobe width watch: the driver's duty, flagged for visibility
    // the block keeps shifting on an overlong strobe; the flag only
    // tells the host that later contents may be suspect
    expander_pkg::strobe_state_t st_r;
    logic [31:0]                 width_r;
    logic                        width_at_limit;

    // limit compare kept outside the case to keep the state logic small
    assign width_at_limit = (width_r >= 32'(expander_pkg::STROBE_MAX_CYC));

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_r    <= expander_pkg::STROBE_IDLE;
            width_r <= 32'h0000_0000;
        end
        else
        begin
            case (st_r)
                expander_pkg::STROBE_IDLE:
                begin
                    width_r <= 32'h0000_0000;
                    if (rise)
                        st_r <= expander_pkg::STROBE_HIGH;
                end
                expander_pkg::STROBE_HIGH:
                begin
                    width_r <= width_r + 32'h0000_0001;
                    if (!strobe_d_r)
                        st_r <= expander_pkg::STROBE_IDLE;
                    else if (width_at_limit)
                        st_r <= expander_pkg::STROBE_LATE;
                end
                expander_pkg::STROBE_LATE:
                begin
                    if (!strobe_d_r)
                        st_r <= expander_pkg::STROBE_IDLE;
                end
                default:
                    st_r <= expander_pkg::STROBE_IDLE;
            endcase
        end
    end

    // level flag: clears once the strobe is seen low, but a drop
    // stays set until reset so a lost bit is never hidden
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            strobe_overlong <= 1'b0;
        else
            strobe_overlong <= (st_r == expander_pkg::STROBE_LATE) || drop_r;
    end

endmodule

// file: expander_checker.sv
// checker for the ten-bit serial output expander
// assumes pins driven on mclk edges, strobe rises 9 cycles apart
`timescale 1ns/10ps
module expander_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // pins
    input wire logic       shift_strobe,
    input wire logic       serial_in,
    input wire logic       output_gate,
    input wire logic [9:0] parallel_out,
    input wire logic       serial_out,
    input wire logic       strobe_overlong
);
    // ====
    // one domain, so one default clock and reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a sampled strobe edge shows on the pins six cycles later, gate three
    a_reset_clear: assert property ($rose(rst_n) |->
        parallel_out == 10'h000 && !serial_out) else $error("not clear");
    a_first_bit: assert property (
        ($rose(shift_strobe) && output_gate) ##1 output_gate[*6]
        |-> parallel_out[0] == $past(serial_in, 6))
        else $error("stage zero wrong");
    a_shift_chain: assert property (output_gate[*8] ##0
        parallel_out != $past(parallel_out)
        |-> parallel_out[9:1] == $past(parallel_out[8:0]))
        else $error("bad shift");
    a_gate_low_zero: assert property ((!output_gate)[*6]
        |-> parallel_out == 10'h000) else $error("gated not zero");
    a_serial_last: assert property (output_gate[*6]
        |-> serial_out == parallel_out[9]) else $error("serial not last");
    a_serial_steady: assert property ($stable(shift_strobe)[*8]
        |-> $stable(serial_out)) else $error("serial moved");
    a_parallel_steady: assert property (($stable(shift_strobe) &&
        $stable(output_gate))[*8] |-> $stable(parallel_out))
        else $error("parallel moved");
    a_overlong_clear: assert property ((!shift_strobe)[*8]
        |-> !strobe_overlong) else $error("overlong flag");
endmodule

// file: io_port_model.sv
// driving i/o port model for the expander
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
module io_port_model (
    // clock
    input wire logic mclk,
    // pins toward the expander
    output logic     shift_strobe,
    output logic     serial_in,
    output logic     output_gate
);
    // ====
    // pins idle low until first use
    initial
    begin
        shift_strobe = 1'b0;
        serial_in    = 1'b0;
        output_gate  = 1'b0;
    end
    // data moves with the strobe on purpose, the harder case
    task automatic send_bit(input logic b);
        @(posedge mclk);
        shift_strobe <= 1'b1;
        serial_in    <= b;
        repeat (4) @(posedge mclk); // far below the longest width
        shift_strobe <= 1'b0;
        serial_in    <= ~b; // hold over, so show the other level
        repeat (4) @(posedge mclk);
    endtask
    // gate change, then time for it to reach the pins
    task automatic drive_gate(input logic g);
        @(posedge mclk);
        output_gate <= g;
        repeat (6) @(posedge mclk);
    endtask
endmodule

// file: tb_serial_output_expander.sv
// testbench for the ten-bit serial output expander
// assumes the checker and the port model compiled before it
`timescale 1ns/10ps
module tb_serial_output_expander;
    logic       mclk;
    logic       rst_n;
    logic       shift_strobe;
    logic       serial_in;
    logic       output_gate;
    logic [9:0] parallel_out;
    logic       serial_out;
    logic       strobe_overlong;
    logic [9:0] sh;
    logic       gate;
    logic [31:0] seed;
    int         n_mismatch;
    int         checks;
    int         cyc;
    event       chk_ev;
    expander_pkg::expander_out_t q[$];
    // ====
    serial_output_expander i_serial_output_expander (.mclk(mclk),
        .rst_n(rst_n), .shift_strobe(shift_strobe), .serial_in(serial_in),
        .output_gate(output_gate), .parallel_out(parallel_out),
        .serial_out(serial_out), .strobe_overlong(strobe_overlong));
    io_port_model i_io_port_model (.mclk(mclk), .shift_strobe(shift_strobe),
        .serial_in(serial_in), .output_gate(output_gate));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t out %h exp %h", $time, seen, exp);
        end
    endtask
    // expected value noted, then the watcher is woken mid-cycle
    task automatic note();
        q.push_back({gate ? sh : 10'h000, sh[9]});
        @(negedge mclk);
        -> chk_ev;
    endtask
    task automatic shift(input logic b);
        i_io_port_model.send_bit(b);
        sh = {sh[8:0], b};
        note();
    endtask
    task automatic set_gate(input logic g);
        i_io_port_model.drive_gate(g);
        gate = g;
        note();
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watcher: oldest note against what the pins show
    always @(chk_ev)
    begin
        chk({parallel_out, serial_out}, q.pop_front());
        chk({10'h000, strobe_overlong}, 11'h000);
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        seed = 32'h0000_005f;
        sh = 10'h000;
        gate = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        set_gate(1'b1);
        for (int i = 0; i < 30; i++)
        begin
            seed = xs(seed);
            if (i == 20)
                set_gate(1'b0); // shifting on with outputs gated off
            shift(seed[0]);
        end
        set_gate(1'b1);
        // walking one through all stages and out the end
        shift(1'b1);
        for (int i = 0; i < 11; i++)
            shift(1'b0);
        shift(1'b1); // leaves a stage set for the reset to clear
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        sh = 10'h000;
        note();
        @(posedge mclk); // let the watcher take the last note first
        stop_test();
    end
endmodule
bind serial_output_expander expander_checker i_expander_checker (
    .mclk(mclk), .rst_n(rst_n), .shift_strobe(shift_strobe),
    .serial_in(serial_in), .output_gate(output_gate),
    .parallel_out(parallel_out), .serial_out(serial_out),
    .strobe_overlong(strobe_overlong));
